// ===== hw/pbs_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_config_regs #(
   parameter logic [5:0][31:0] BAR_PRESET = '0,
   parameter logic [5:0] BAR_HARDWIRE = 6'h00,
   // 0: no 64-bit pair, 1: BARs 1 and 0, 2: BARs 2 and 1.
   parameter logic [1:0] PAIR_SEL = 2'h0,
   parameter int UPPER_BITS = 8,
   parameter logic CIS_ENABLE = 1'b0,
   parameter logic [2:0] CIS_SPACE = 3'h1,
   parameter logic [24:0] CIS_OFFSET = 25'h0000000,
   parameter logic [3:0] CIS_ROM_IMAGE = 4'h0,
   // Arbitrary identification values.
   parameter logic [15:0] SUBSYS_MAKER = 16'h5A5A,
   parameter logic [15:0] SUBSYS_PRODUCT = 16'hA5A5
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Configuration access.
   input wire pbs_pkg::pbs_cfg_req_t cfg_req,
   output pbs_pkg::pbs_cfg_rsp_t cfg_rsp_ff,
   // Address decode.
   input wire pbs_pkg::pbs_bus_addr_t bus_addr,
   input wire logic mem_space_en,
   input wire logic io_space_en,
   output logic [5:0] claim_ff,
   output logic claim_any_ff
);

   // ========================================================================
   // Slot roles.
   function automatic pbs_pkg::pbs_role_t role_of(input int idx);
      pbs_pkg::pbs_role_t r;
      if (PAIR_SEL == 2'h1 && idx == 0) begin
         r = pbs_pkg::PBS_ROLE_MEM64LO;
      end else if (PAIR_SEL == 2'h1 && idx == 1) begin
         r = pbs_pkg::PBS_ROLE_UPPER;
      end else if (PAIR_SEL == 2'h2 && idx == 1) begin
         r = pbs_pkg::PBS_ROLE_MEM64LO;
      end else if (PAIR_SEL == 2'h2 && idx == 2) begin
         r = pbs_pkg::PBS_ROLE_UPPER;
      end else if (BAR_PRESET[idx] == 32'h0000_0000) begin
         r = pbs_pkg::PBS_ROLE_NONE;
      end else if (BAR_PRESET[idx][0]) begin
         r = pbs_pkg::PBS_ROLE_IO;
      end else begin
         r = pbs_pkg::PBS_ROLE_MEM32;
      end
      return r;
   endfunction

   function automatic logic [5:0] bar_dword(input int idx);
      logic [7:0] off;
      off = `PBS_OFF_BAR0 + 8'(idx * 4);
      return off[7:2];
   endfunction

   // ========================================================================
   // Base windows.
   logic [5:0][31:0] slot_rd;
   logic [5:0][31:0] slot_base;
   logic [5:0][31:0] slot_mask;
   logic [5:0] slot_hit;

   for (genvar i = 0; i < 6; i++) begin : g_slot
      localparam pbs_pkg::pbs_role_t ROLE = role_of(i);
      localparam int HI = (i == 5) ? 5 : i + 1;
      logic wr_hit;

      assign wr_hit = cfg_req.valid && cfg_req.write && (cfg_req.dword == bar_dword(i));

      pbs_bar_slot #(
         .ROLE(ROLE),
         .PRESET(BAR_PRESET[i]),
         .HARDWIRE(BAR_HARDWIRE[i]),
         .UPPER_BITS(UPPER_BITS)
      ) u_slot (
         .core_clk(core_clk),
         .reset(reset),
         .wr_en(wr_hit),
         .wr_be(cfg_req.byte_en),
         .wr_data(cfg_req.data),
         .rd_value(slot_rd[i]),
         .dec_base(slot_base[i]),
         .dec_mask(slot_mask[i])
      );

      // The upper half of a pair never claims on its own.
      pbs_window_match u_match (
         .want_io(ROLE == pbs_pkg::PBS_ROLE_IO),
         .is64(ROLE == pbs_pkg::PBS_ROLE_MEM64LO),
         .base_lo(slot_base[i]),
         .mask_lo((ROLE == pbs_pkg::PBS_ROLE_UPPER) ? 32'h0000_0000 : slot_mask[i]),
         .base_hi(slot_base[HI]),
         .mask_hi(slot_mask[HI]),
         .mem_space_en(mem_space_en),
         .io_space_en(io_space_en),
         .bus(bus_addr),
         .hit(slot_hit[i])
      );
   end

   // ========================================================================
   // Read-only identity registers.
   logic [31:0] cis_value;
   logic [31:0] subsys_value;

   always_comb begin
      cis_value = 32'h0000_0000;
      // A pointer into configuration space is not offered; it reads as absent.
      if (CIS_ENABLE && CIS_SPACE != `PBS_CIS_SPACE_CONFIG) begin
         cis_value[`PBS_CIS_SPACE_LSB +: 3] = CIS_SPACE;
         cis_value[`PBS_CIS_OFFSET_LSB +: 25] = CIS_OFFSET;
         cis_value[`PBS_CIS_ROM_LSB +: 4] = CIS_ROM_IMAGE;
      end
      subsys_value = 32'h0000_0000;
      subsys_value[`PBS_SUBSYS_MAKER_LSB +: 16] = SUBSYS_MAKER;
      subsys_value[`PBS_SUBSYS_PRODUCT_LSB +: 16] = SUBSYS_PRODUCT;
   end

   // ========================================================================
   // Response and claim registers.
   pbs_pkg::pbs_cfg_rsp_t nxt_cfg_rsp_ff;
   logic [5:0] nxt_claim_ff;
   logic nxt_claim_any_ff;

   always_comb begin
      nxt_cfg_rsp_ff.ack = cfg_req.valid;
      nxt_cfg_rsp_ff.data = `PBS_RDATA_RST;
      // Writes are acknowledged with zero data; the read-only words simply keep their value.
      if (cfg_req.valid && !cfg_req.write) begin
         if (cfg_req.dword == 6'(`PBS_OFF_CIS >> 2)) begin
            nxt_cfg_rsp_ff.data = cis_value;
         end else if (cfg_req.dword == 6'(`PBS_OFF_SUBSYS >> 2)) begin
            nxt_cfg_rsp_ff.data = subsys_value;
         end else begin
            for (int i = 0; i < 6; i++) begin
               if (cfg_req.dword == bar_dword(i)) begin
                  nxt_cfg_rsp_ff.data = slot_rd[i];
               end
            end
         end
      end
      nxt_claim_ff = slot_hit;
      nxt_claim_any_ff = |slot_hit;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cfg_rsp_ff <= '0;
         claim_ff <= 6'h00;
         claim_any_ff <= 1'b0;
      end else begin
         cfg_rsp_ff <= nxt_cfg_rsp_ff;
         claim_ff <= nxt_claim_ff;
         claim_any_ff <= nxt_claim_any_ff;
      end
   end

endmodule // pbs_config_regs

`default_nettype wire

// ===== hw/pbs_defs.svh
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

// ==========================================================================
// Configuration space byte offsets.
`define PBS_OFF_BAR0 8'h10
`define PBS_OFF_CIS 8'h28
`define PBS_OFF_SUBSYS 8'h2C

// ==========================================================================
// Field positions.
`define PBS_CIS_SPACE_LSB 0
`define PBS_CIS_OFFSET_LSB 3
`define PBS_CIS_ROM_LSB 28
`define PBS_SUBSYS_MAKER_LSB 0
`define PBS_SUBSYS_PRODUCT_LSB 16

// ==========================================================================
// Masks and reset values.
`define PBS_MEM_BASE_MASK 32'hFFFF_FFF0
`define PBS_IO_BASE_MASK 32'hFFFF_FFFC
`define PBS_IO_MIN_MASK 32'hFFFF_FF00
`define PBS_MEM_PREFETCH_MASK 32'h0000_0008
`define PBS_MEM64_TYPE 32'h0000_0004
`define PBS_IO_INDICATOR 32'h0000_0001
`define PBS_BAR_RST 32'h0000_0000
`define PBS_RDATA_RST 32'h0000_0000
`define PBS_CIS_SPACE_CONFIG 3'h0

`endif

// ===== hw/pbs_pkg.sv
package pbs_pkg;

   // ========================================================================
   // Types.
   typedef enum logic [4:0] {
      PBS_ROLE_NONE = 5'h01,
      PBS_ROLE_MEM32 = 5'h02,
      PBS_ROLE_MEM64LO = 5'h04,
      PBS_ROLE_UPPER = 5'h08,
      PBS_ROLE_IO = 5'h10
   } pbs_role_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] dword;
      logic [3:0] byte_en;
      logic [31:0] data;
   } pbs_cfg_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] data;
   } pbs_cfg_rsp_t;

   typedef struct packed {
      logic valid;
      logic is_io;
      logic [63:0] addr;
   } pbs_bus_addr_t;

   // Keeps only the unbroken run of ones from bit 31 downward.
   function automatic logic [31:0] pbs_lead_ones(input logic [31:0] v);
      logic [31:0] m;
      logic run;
      m = '0;
      run = 1'b1;
      for (int b = 31; b >= 0; b--) begin
         run = run & v[b];
         m[b] = run;
      end
      return m;
   endfunction

endpackage

// ===== hw/pbs_bar_slot.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_bar_slot #(
   parameter pbs_pkg::pbs_role_t ROLE = pbs_pkg::PBS_ROLE_NONE,
   parameter logic [31:0] PRESET = 32'h0000_0000,
   parameter logic HARDWIRE = 1'b0,
   parameter int UPPER_BITS = 8
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Write strobe with data.
   input wire logic wr_en,
   input wire logic [3:0] wr_be,
   input wire logic [31:0] wr_data,
   // Read value and decode window.
   output logic [31:0] rd_value,
   output logic [31:0] dec_base,
   output logic [31:0] dec_mask
);

   // ========================================================================
   // Writable mask and fixed bits.
   logic [31:0] wmask;
   logic [31:0] fixed;
   logic [31:0] base_ff;
   logic [31:0] nxt_base_ff;

   always_comb begin
      unique case (ROLE)
         pbs_pkg::PBS_ROLE_MEM32: begin
            wmask = pbs_pkg::pbs_lead_ones(PRESET) & `PBS_MEM_BASE_MASK;
            fixed = PRESET & `PBS_MEM_PREFETCH_MASK;
         end
         pbs_pkg::PBS_ROLE_MEM64LO: begin
            wmask = `PBS_MEM_BASE_MASK;
            fixed = (PRESET & `PBS_MEM_PREFETCH_MASK) | `PBS_MEM64_TYPE;
         end
         pbs_pkg::PBS_ROLE_UPPER: begin
            wmask = ~(32'hFFFF_FFFF << UPPER_BITS);
            fixed = 32'h0000_0000;
         end
         pbs_pkg::PBS_ROLE_IO: begin
            // Bits from 8 upward are always decoded so no window exceeds 256 bytes.
            wmask = (pbs_pkg::pbs_lead_ones(PRESET) | `PBS_IO_MIN_MASK)
                    & `PBS_IO_BASE_MASK;
            fixed = `PBS_IO_INDICATOR;
         end
         pbs_pkg::PBS_ROLE_NONE: begin
            wmask = 32'h0000_0000;
            fixed = 32'h0000_0000;
         end
      endcase
   end

   // ========================================================================
   // Base storage.
   always_comb begin
      nxt_base_ff = base_ff;
      if (wr_en && !HARDWIRE) begin
         for (int l = 0; l < 4; l++) begin
            if (wr_be[l]) begin
               nxt_base_ff[l*8 +: 8] = wr_data[l*8 +: 8] & wmask[l*8 +: 8];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         base_ff <= `PBS_BAR_RST;
      end else begin
         base_ff <= nxt_base_ff;
      end
   end

   assign rd_value = HARDWIRE ? PRESET : ((base_ff & wmask) | fixed);
   assign dec_base = HARDWIRE ? (PRESET & wmask) : (base_ff & wmask);
   assign dec_mask = wmask;

endmodule // pbs_bar_slot

`default_nettype wire

// ===== hw/pbs_window_match.sv
`timescale 1ns/1ps
`default_nettype none

module pbs_window_match (
   // Window description.
   input wire logic want_io,
   input wire logic is64,
   input wire logic [31:0] base_lo,
   input wire logic [31:0] mask_lo,
   input wire logic [31:0] base_hi,
   input wire logic [31:0] mask_hi,
   // Space enables.
   input wire logic mem_space_en,
   input wire logic io_space_en,
   // Bus address.
   input wire pbs_pkg::pbs_bus_addr_t bus,
   output logic hit
);

   logic lo_ok;
   logic hi_ok;
   logic space_ok;

   always_comb begin
      lo_ok = (((bus.addr[31:0] ^ base_lo) & mask_lo) == 32'h0000_0000);
      // A 32-bit memory window only answers below 4 GBytes.
      if (is64) begin
         hi_ok = (((bus.addr[63:32] ^ base_hi) & mask_hi) == 32'h0000_0000);
      end else begin
         hi_ok = want_io || (bus.addr[63:32] == 32'h0000_0000);
      end
      space_ok = want_io ? (bus.is_io && io_space_en) : (!bus.is_io && mem_space_en);
      hit = bus.valid && space_ok && (mask_lo != 32'h0000_0000) && lo_ok && hi_ok;
   end

endmodule // pbs_window_match

`default_nettype wire

// ===== tb/pbs_config_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pbs_config_regs_chk #(
   parameter logic [15:0] SUBSYS_MAKER = 16'h5A5A,
   parameter logic [15:0] SUBSYS_PRODUCT = 16'hA5A5
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Configuration access.
   input wire pbs_pkg::pbs_cfg_req_t cfg_req,
   input wire pbs_pkg::pbs_cfg_rsp_t cfg_rsp_ff,
   // Address decode.
   input wire pbs_pkg::pbs_bus_addr_t bus_addr,
   input wire logic mem_space_en,
   input wire logic io_space_en,
   input wire logic [5:0] claim_ff,
   input wire logic claim_any_ff
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ======================================================================
   // Request shapes.
   sequence s_take;
      cfg_req.valid;
   endsequence
   sequence s_rd(lo, hi);
      cfg_req.valid && !cfg_req.write && cfg_req.dword >= lo && cfg_req.dword <= hi;
   endsequence
   // ======================================================================
   // Properties.
   AST_ACK_NEXT: assert property (s_take |=> cfg_rsp_ff.ack)
      else $error("request not acknowledged one cycle later");
   AST_ACK_CAUSE: assert property (cfg_rsp_ff.ack |-> $past(cfg_req.valid))
      else $error("acknowledge without a request");
   AST_WR_DATA: assert property (s_take ##0 cfg_req.write |=> cfg_rsp_ff.data == 32'h0)
      else $error("write answer carries data");
   AST_SUBSYS: assert property (s_rd(6'h0B, 6'h0B) |=>
      cfg_rsp_ff.data == {SUBSYS_PRODUCT, SUBSYS_MAKER})
      else $error("subsystem codes read wrong");
   // A pointer into configuration space is never offered; a disabled one reads zero.
   AST_CIS_SPACE: assert property (s_rd(6'h0A, 6'h0A) |=>
      cfg_rsp_ff.data == 32'h0 || cfg_rsp_ff.data[2:0] != 3'h0)
      else $error("card info pointer names configuration space");
   AST_BAR_BIT1: assert property (s_rd(6'h04, 6'h09) |=> !cfg_rsp_ff.data[1])
      else $error("window bit 1 read as one");
   AST_CLAIM_CAUSE: assert property (claim_any_ff |-> $past(bus_addr.valid) &&
      ($past(mem_space_en) || $past(io_space_en)))
      else $error("claim without an enabled address phase");
   AST_CLAIM_OR: assert property (claim_any_ff == (claim_ff != 6'h00))
      else $error("summary claim disagrees with window claims");
   AST_IO_GATED: assert property (bus_addr.valid && bus_addr.is_io && !io_space_en |=>
      !claim_any_ff)
      else $error("I/O claim while I/O decode is off");
endmodule // pbs_config_regs_chk
bind pbs_config_regs pbs_config_regs_chk #(
   .SUBSYS_MAKER(SUBSYS_MAKER),
   .SUBSYS_PRODUCT(SUBSYS_PRODUCT)
) pbs_config_regs_chk_inst (.core_clk, .reset, .cfg_req, .cfg_rsp_ff, .bus_addr,
   .mem_space_en, .io_space_en, .claim_ff, .claim_any_ff);
`default_nettype wire

// ===== tb/pbs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Configuration host. Released request lines carry inverted values so stale data is never mistaken.
module pbs_host_model (
   // Clock.
   input wire logic core_clk,
   // Configuration access.
   output pbs_pkg::pbs_cfg_req_t cfg_req,
   input wire pbs_pkg::pbs_cfg_rsp_t cfg_rsp_ff,
   // Address phase.
   output pbs_pkg::pbs_bus_addr_t bus_addr
);
   initial begin
      cfg_req = '0;
      bus_addr = '0;
   end
   task automatic access(input logic w, input logic [5:0] dw, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      ok = 1'b0;
      q = 32'h0;
      @(posedge core_clk);
      cfg_req <= '{1'b1, w, dw, be, d};
      @(posedge core_clk);
      cfg_req <= '{1'b0, ~w, ~dw, ~be, ~d};
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge core_clk);
         if (cfg_rsp_ff.ack === 1'b1) begin
            ok = 1'b1;
            q = cfg_rsp_ff.data;
         end
      end
   endtask
   task automatic put_addr(input logic v, input logic io, input logic [63:0] a);
      @(posedge core_clk);
      bus_addr <= '{v, io, a};
      @(posedge core_clk);
   endtask
endmodule // pbs_host_model
`default_nettype wire

// ===== tb/pbs_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pbs_config_regs_bench;
   // ======================================================================
   // Clock, reset and wiring.
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic mem_space_en = 1'b0;
   logic io_space_en = 1'b0;
   pbs_pkg::pbs_cfg_req_t cfg_req;
   pbs_pkg::pbs_cfg_rsp_t cfg_rsp_ff;
   pbs_pkg::pbs_bus_addr_t bus_addr;
   logic [5:0] claim_ff;
   logic claim_any_ff;
   int err_count = 0;
   int n_tests = 0;
   always #25 core_clk = ~core_clk;
   // Pair on windows 2 and 1, window 3 is I/O, window 4 hardwired, window 5 unused.
   pbs_config_regs #(
      .BAR_PRESET({32'h0, 32'hC000_0000, 32'hFFFF_FF01, 32'h0, 32'h0000_0004, 32'hFFFF_F000}),
      .BAR_HARDWIRE(6'h10), .PAIR_SEL(2'h2), .CIS_ENABLE(1'b1),
      .CIS_OFFSET(25'h0000123), .CIS_ROM_IMAGE(4'h5)
   ) pbs_config_regs_inst (.core_clk, .reset, .cfg_req, .cfg_rsp_ff, .bus_addr,
      .mem_space_en, .io_space_en, .claim_ff, .claim_any_ff);
   pbs_host_model pbs_host_model_inst (.core_clk, .cfg_req, .cfg_rsp_ff, .bus_addr);
   // ======================================================================
   // Shared tasks.
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic acc(input logic w, input logic [5:0] dw, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
      logic ok;
      pbs_host_model_inst.access(w, dw, be, d, q, ok);
      if (ok !== 1'b1) begin
         err_count++;
         stop_test();
      end
   endtask
   task automatic probe(input logic io, input logic [63:0] a, input logic [5:0] exp);
      pbs_host_model_inst.put_addr(1'b1, io, a);
      @(negedge core_clk);
      chk("claim", {26'h0, claim_ff}, {26'h0, exp});
      chk("claim any", {31'h0, claim_any_ff}, {31'h0, exp != 6'h00});
      pbs_host_model_inst.put_addr(1'b0, ~io, ~a);
   endtask
   // ======================================================================
   // Scenarios.
   task automatic t_reset_values();
      logic [31:0] q;
      logic [31:0] exp [6] = '{32'h0, 32'h4, 32'h0, 32'h1, 32'hC000_0000, 32'h0};
      for (int i = 0; i < 6; i++) begin
         acc(1'b0, 6'h04 + 6'(i), 4'hF, 32'h0, q);
         chk("window after reset", q, exp[i]);
      end
   endtask
   // All ones written everywhere exposes exactly which bits are writable.
   task automatic t_write_all();
      logic [31:0] q;
      logic [31:0] exp [8] = '{32'hFFFF_F000, 32'hFFFF_FFF4, 32'h0000_00FF, 32'hFFFF_FF01,
         32'hC000_0000, 32'h0, 32'h5000_0919, 32'hA5A5_5A5A};
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, 6'h04 + 6'(i), 4'hF, 32'hFFFF_FFFF, q);
      end
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, 6'h04 + 6'(i), 4'hF, 32'h0, q);
         chk("read back", q, exp[i]);
      end
   endtask
   task automatic t_bytes();
      logic [31:0] q;
      acc(1'b1, 6'h04, 4'h2, 32'h0, q);
      acc(1'b0, 6'h04, 4'hF, 32'h0, q);
      chk("lane write", q, 32'hFFFF_0000);
      acc(1'b1, 6'h07, 4'h1, 32'h0, q);
      acc(1'b0, 6'h07, 4'hF, 32'h0, q);
      chk("io low lane", q, 32'hFFFF_FF01);
   endtask
   task automatic t_decode();
      logic [31:0] q;
      acc(1'b1, 6'h04, 4'hF, 32'h1234_5000, q);
      acc(1'b1, 6'h05, 4'hF, 32'h8000_0000, q);
      acc(1'b1, 6'h06, 4'hF, 32'h0000_0012, q);
      acc(1'b1, 6'h07, 4'hF, 32'h0000_AB00, q);
      probe(1'b0, 64'h0000_0000_1234_5ABC, 6'h01);
      probe(1'b0, 64'h0000_0012_8000_0008, 6'h02);
      probe(1'b0, 64'h8000_0000_0000_0012, 6'h00);
      probe(1'b1, 64'h0000_0000_0000_AB10, 6'h08);
      probe(1'b1, 64'h0000_0000_0000_AC10, 6'h00);
      probe(1'b0, 64'h0000_0000_C000_0040, 6'h10);
      probe(1'b1, 64'h0000_0000_1234_5ABC, 6'h00);
      @(posedge core_clk);
      io_space_en <= 1'b0;
      probe(1'b1, 64'h0000_0000_0000_AB10, 6'h00);
      @(posedge core_clk);
      mem_space_en <= 1'b0;
      probe(1'b0, 64'h0000_0000_C000_0040, 6'h00);
      @(posedge core_clk);
      mem_space_en <= 1'b1;
      io_space_en <= 1'b1;
   endtask
   // A reset in mid-run must clear programmed bases but never the hardwired one.
   task automatic t_mid_reset();
      logic [31:0] q;
      acc(1'b1, 6'h04, 4'hF, 32'h1234_5000, q);
      pbs_host_model_inst.put_addr(1'b1, 1'b0, 64'h0000_0000_1234_5000);
      @(posedge core_clk);
      reset <= 1'b1;
      @(negedge core_clk);
      chk("claim in reset", {26'h0, claim_ff}, 32'h0);
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      chk("claim after reset", {26'h0, claim_ff}, 32'h0);
      pbs_host_model_inst.put_addr(1'b0, 1'b1, 64'h0);
      acc(1'b0, 6'h04, 4'hF, 32'h0, q);
      chk("window 0 after reset", q, 32'h0);
      acc(1'b0, 6'h08, 4'hF, 32'h0, q);
      chk("hardwired after reset", q, 32'hC000_0000);
   endtask
   // ======================================================================
   // Main sequence.
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      mem_space_en <= 1'b1;
      io_space_en <= 1'b1;
      t_reset_values();
      t_write_all();
      t_bytes();
      t_decode();
      t_mid_reset();
      stop_test();
   end
endmodule // pbs_config_regs_bench
`default_nettype wire
